// ==== src/loop_det_output.sv ====
// Loop detector output timing: delay, extension, pulse and output drive per channel
//
// Function
// - Extension mode holds output after departure for set time, then releases
// - Re-entry during extension clears timer, holds output, restarts on departure
// - Extension setting spans zero to seven and a half seconds
// - Extension settable in half-second steps
// - Extension interval accurate within half a second
// - Timing-allow inactive gives no extension or delay
// - Timing-block active gives no extension or delay
// - Separate indicator per channel follows detection output
// - Reset control forces channel back to no-vehicle state
// - Pulse or presence output selectable per channel
// - Three timing choices: delay, extension, normal
// - Normal also selected by a zero timing setting
// - Per-channel timing duration setting
// - Relay closes on detection, opens otherwise
// - Relay drive is closed-on-deenergise so power loss reads detection
// - Relay closed while loop is open
// - Solid-state output conducts on detection, off otherwise
// - Solid-state output off on power loss
// - Solid-state output conducts while loop is open
// - Delay mode asserts after set presence time, else clears timer
// - Delay setting spans zero to thirty seconds
// - Pulse mode gives one 120 ms pulse on vehicle entry
`timescale 1ns/1ps
module loop_det_output #(
    parameter int unsigned NCH         = 2,
    parameter int unsigned TICK_CYCLES = loop_det_pkg::TICK_CYCLES
) (
    input  wire logic           core_clk_i,
    input  wire logic           rst_n_i,
    // Front end and controller inputs, asynchronous to core_clk_i
    input  wire logic [NCH-1:0] presence_i,
    input  wire logic [NCH-1:0] loop_open_i,
    input  wire logic [NCH-1:0] timing_allow_i,
    input  wire logic [NCH-1:0] timing_block_i,
    // APB slave
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [7:0]     paddr_i,
    input  wire logic [31:0]    pwdata_i,
    output logic      [31:0]    prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    // Outputs
    output logic      [NCH-1:0] detect_o,
    output logic      [NCH-1:0] relay_coil_o,
    output logic      [NCH-1:0] ssr_on_o,
    output logic      [NCH-1:0] indicator_o
);

    initial begin
        if (NCH < 1 || NCH > 3) begin
            $error("NCH must be 1..3");
        end
        // Divider counter is 24 bits and needs at least two states
        if (TICK_CYCLES < 2 || TICK_CYCLES > 16777216) begin
            $error("TICK_CYCLES out of range");
        end
    end

    localparam int unsigned TW  = loop_det_pkg::TMR_W;
    localparam int unsigned FW  = loop_det_pkg::CH_FIELD_W;

    // Span in ticks for the whole time field value, by mode
    function automatic logic [TW-1:0] span_ticks(input logic [1:0] md, input logic [4:0] tv);
        logic [TW-1:0] unit;
        unit = (md == loop_det_pkg::MODE_EXT) ? TW'(loop_det_pkg::STEP_TICKS) : TW'(loop_det_pkg::SEC_TICKS);
        span_ticks = TW'(tv) * unit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Tick divider

    logic [23:0] div_cnt;
    logic        tick;

    // One shared tick keeps all channel timers in step
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 24'h000000;
            tick    <= 1'b0;
        end else if (div_cnt == 24'(TICK_CYCLES - 1)) begin
            div_cnt <= 24'h000000;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 24'h000001;
            tick    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [NCH-1:0] pres_m, pres_s, lopen_m, lopen_s, allow_m, allow_s, block_m, block_s;

    // Two flops on every front end and controller input before any logic reads it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pres_m  <= '0;
            pres_s  <= '0;
            lopen_m <= '0;
            lopen_s <= '0;
            allow_m <= '0;
            allow_s <= '0;
            block_m <= '0;
            block_s <= '0;
        end else begin
            pres_m  <= presence_i;
            pres_s  <= pres_m;
            lopen_m <= loop_open_i;
            lopen_s <= lopen_m;
            allow_m <= timing_allow_i;
            allow_s <= allow_m;
            block_m <= timing_block_i;
            block_s <= block_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB registers

    logic [NCH*FW-1:0] ctrl;
    logic [NCH-1:0]    retune;
    logic              acc;

    assign acc = psel_i && penable_i;

    // Control writes; retune is a one-cycle strobe per channel
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl   <= {NCH{loop_det_pkg::CTRL_RESET}};
            retune <= '0;
        end else begin
            retune <= '0;
            if (acc && pwrite_i && paddr_i == loop_det_pkg::ADDR_CTRL) begin
                ctrl <= pwdata_i[NCH*FW-1:0];
            end
            if (acc && pwrite_i && paddr_i == loop_det_pkg::ADDR_RETUNE) begin
                retune <= pwdata_i[NCH-1:0];
            end
        end
    end

    // Read data and zero-wait answer; unmapped address flags an error
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
            if (psel_i && !penable_i) begin
                case (paddr_i)
                    loop_det_pkg::ADDR_CTRL:   prdata_o <= 32'(ctrl);
                    loop_det_pkg::ADDR_STATUS: prdata_o <= {16'h0000, 8'(pres_s), 8'(detect_o)};
                    loop_det_pkg::ADDR_RETUNE: prdata_o <= 32'h00000000;
                    loop_det_pkg::ADDR_ID:     prdata_o <= loop_det_pkg::ID_VALUE;
                    default:                   pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel timing

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            logic [1:0]             md;
            logic [4:0]             tv;
            logic                   pulse_sel, ssr_sel, no_time, prev_veh;
            logic [TW-1:0]          tmr;
            logic [TW-1:0]          span;
            loop_det_pkg::ch_state_e st;
            logic [TW-1:0]          pcnt;
            logic                   pres_out;
            logic                   det;

            assign md        = ctrl[g*FW+loop_det_pkg::F_MODE_LSB +: 2];
            assign tv        = ctrl[g*FW+loop_det_pkg::F_TIME_LSB +: 5];
            assign pulse_sel = ctrl[g*FW+loop_det_pkg::F_PULSE];
            assign ssr_sel   = ctrl[g*FW+loop_det_pkg::F_SSTATE];
            // Extension clamps at 15 half-seconds, delay at 30 seconds
            assign span      = span_ticks(md, (md == loop_det_pkg::MODE_EXT && tv > 5'(loop_det_pkg::EXT_MAX_STEPS))
                                   ? 5'(loop_det_pkg::EXT_MAX_STEPS)
                                   : (tv > 5'(loop_det_pkg::DLY_MAX_SECONDS) ? 5'(loop_det_pkg::DLY_MAX_SECONDS) : tv));
            // Timing is skipped when not allowed, blocked, normal or zero
            assign no_time   = !allow_s[g] || block_s[g] || md == loop_det_pkg::MODE_NORMAL
                               || md == 2'h3 || tv == 5'h00;
            // Presence state machine: delay before, extension after
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    st       <= loop_det_pkg::ST_IDLE;
                    tmr      <= '0;
                    pres_out <= 1'b0;
                end else if (retune[g]) begin
                    st       <= loop_det_pkg::ST_IDLE;
                    tmr      <= '0;
                    pres_out <= 1'b0;
                end else begin
                    case (st)
                        loop_det_pkg::ST_IDLE: begin
                            tmr <= '0;
                            if (pres_s[g]) begin
                                if (!no_time && md == loop_det_pkg::MODE_DELAY) begin
                                    st <= loop_det_pkg::ST_DELAY;
                                end else begin
                                    st       <= loop_det_pkg::ST_ON;
                                    pres_out <= 1'b1;
                                end
                            end
                        end
                        loop_det_pkg::ST_DELAY: begin
                            if (!pres_s[g]) begin
                                st  <= loop_det_pkg::ST_IDLE;
                                tmr <= '0;
                            end else if (no_time || tmr >= span) begin
                                st       <= loop_det_pkg::ST_ON;
                                pres_out <= 1'b1;
                            end else if (tick) begin
                                tmr <= tmr + TW'(1);
                            end
                        end
                        loop_det_pkg::ST_ON: begin
                            tmr <= '0;
                            if (!pres_s[g]) begin
                                if (!no_time && md == loop_det_pkg::MODE_EXT) begin
                                    st <= loop_det_pkg::ST_EXT;
                                end else begin
                                    st       <= loop_det_pkg::ST_IDLE;
                                    pres_out <= 1'b0;
                                end
                            end
                        end
                        loop_det_pkg::ST_EXT: begin
                            if (pres_s[g]) begin
                                st  <= loop_det_pkg::ST_ON;
                                tmr <= '0;
                            end else if (no_time || tmr >= span) begin
                                st       <= loop_det_pkg::ST_IDLE;
                                pres_out <= 1'b0;
                            end else if (tick) begin
                                tmr <= tmr + TW'(1);
                            end
                        end
                        default: begin
                            st       <= loop_det_pkg::ST_IDLE;
                            tmr      <= '0;
                            pres_out <= 1'b0;
                        end
                    endcase
                end
            end

            // Pulse mode: one fixed pulse per entry edge that arrives while no pulse is running
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    prev_veh <= 1'b0;
                    pcnt     <= '0;
                end else if (retune[g]) begin
                    prev_veh <= pres_s[g];
                    pcnt     <= '0;
                end else begin
                    prev_veh <= pres_s[g];
                    if (pres_s[g] && !prev_veh && pcnt == '0) begin
                        pcnt <= TW'(loop_det_pkg::PULSE_TICKS);
                    end else if (tick && pcnt != '0) begin
                        pcnt <= pcnt - TW'(1);
                    end
                end
            end

            // Open loop always forces detection
            assign det = lopen_s[g] || (pulse_sel ? (pcnt != '0) : pres_out);

            // Output flops; relay coil energised means contacts open
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    detect_o[g]     <= 1'b0;
                    relay_coil_o[g] <= 1'b0;
                    ssr_on_o[g]     <= 1'b0;
                    indicator_o[g]  <= 1'b0;
                end else begin
                    detect_o[g]     <= det;
                    relay_coil_o[g] <= !ssr_sel && !det;
                    ssr_on_o[g]     <= ssr_sel && det;
                    indicator_o[g]  <= det;
                end
            end
        end
    endgenerate

endmodule

// ==== src/loop_det_pkg.sv ====
// Package with constants for the loop detector output timing block
package loop_det_pkg;
    // Tick period in milliseconds and the clock rate
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned TICK_MS         = 10;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    // Pulse width, within the 100..150 ms window
    localparam int unsigned PULSE_MS        = 120;
    localparam int unsigned PULSE_TICKS     = PULSE_MS / TICK_MS;
    // Half-second step expressed in ticks
    localparam int unsigned STEP_MS         = 500;
    localparam int unsigned STEP_TICKS      = STEP_MS / TICK_MS;
    // Settings: extension 0..15 half seconds, delay 0..30 seconds
    localparam int unsigned EXT_MAX_STEPS   = 15;
    localparam int unsigned DLY_MAX_SECONDS = 30;
    localparam int unsigned SEC_TICKS       = 1000 / TICK_MS;
    localparam int unsigned TMR_W           = 12;

    // Register map (APB byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RETUNE = 8'h08;
    localparam logic [7:0] ADDR_ID     = 8'h0c;
    // Per-channel 9-bit control field layout
    localparam int unsigned F_MODE_LSB   = 0;   // 2 bits timing mode
    localparam int unsigned F_PULSE      = 2;   // 1 pulse, 0 presence
    localparam int unsigned F_SSTATE     = 3;   // 1 solid state, 0 relay
    localparam int unsigned F_TIME_LSB   = 4;   // 5 bits: ext half-seconds or delay seconds
    localparam int unsigned CH_FIELD_W   = 9;
    localparam logic [CH_FIELD_W-1:0] CTRL_RESET = 9'h000;
    // Arbitrary neutral identity value
    localparam logic [31:0] ID_VALUE = 32'h0000_0001;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_DELAY  = 2'h1,
        MODE_EXT    = 2'h2
    } tmode_e;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_DELAY = 4'h2,
        ST_ON    = 4'h4,
        ST_EXT   = 4'h8
    } ch_state_e;
endpackage

// ==== bench/loop_det_output_monitor.sv ====
// Port checker for the loop detector output block
`timescale 1ns/1ps
module loop_det_output_monitor #(
    parameter int unsigned NCH = 2
) (
    input wire logic           core_clk_i,
    input wire logic           rst_n_i,
    input wire logic [NCH-1:0] presence_i,
    input wire logic [NCH-1:0] loop_open_i,
    input wire logic [NCH-1:0] timing_allow_i,
    input wire logic [NCH-1:0] timing_block_i,
    input wire logic           psel_i,
    input wire logic           penable_i,
    input wire logic           pwrite_i,
    input wire logic [7:0]     paddr_i,
    input wire logic [31:0]    pwdata_i,
    input wire logic [31:0]    prdata_o,
    input wire logic           pready_o,
    input wire logic           pslverr_o,
    input wire logic [NCH-1:0] detect_o,
    input wire logic [NCH-1:0] relay_coil_o,
    input wire logic [NCH-1:0] ssr_on_o,
    input wire logic [NCH-1:0] indicator_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic           setup;
    logic           rt_wr;
    logic           ct_wr;
    logic [NCH-1:0] relay_ch;
    ////////////////////////////////////////////////////////////////////////////
    // Bus phases; the coil is judged only on channels set up for relay
    assign setup = psel_i && !penable_i;
    assign ct_wr = psel_i && penable_i && pwrite_i && pready_o;
    assign rt_wr = ct_wr && paddr_i == loop_det_pkg::ADDR_RETUNE && pwdata_i[0];
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            relay_ch <= '1;
        end else if (ct_wr && paddr_i == loop_det_pkg::ADDR_CTRL) begin
            for (int g = 0; g < NCH; g++) begin
                relay_ch[g] <= !pwdata_i[g*9+3];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    AST_IND: assert property (indicator_o == detect_o)
        else $error("indicator differs from detect");
    AST_COIL: assert property ((relay_coil_o & relay_ch & $past(relay_ch) & detect_o & $past(detect_o)) == '0)
        else $error("relay open during detect");
    AST_SSR: assert property ((ssr_on_o & ~detect_o & ~$past(detect_o)) == '0)
        else $error("solid-state on without detect");
    AST_OPEN: assert property ((loop_open_i == '1)[*5] |-> detect_o == '1)
        else $error("open loop not reported");
    AST_RETUNE: assert property ((!presence_i[0] && !loop_open_i[0])[*6] ##0 rt_wr |-> ##[1:3] !detect_o[0])
        else $error("retune kept detection");
    AST_RDY: assert property (setup |=> pready_o)
        else $error("no ready after setup");
    AST_PULSE: assert property (pready_o |-> psel_i && penable_i ##1 !pready_o)
        else $error("ready outside one access cycle");
    AST_ERR: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    AST_ID: assert property (setup && !pwrite_i && paddr_i == loop_det_pkg::ADDR_ID |=> prdata_o == 32'h0000_0001)
        else $error("identity read wrong");
    AST_MAP: assert property (setup && paddr_i > loop_det_pkg::ADDR_ID |=> pslverr_o)
        else $error("unmapped access not refused");
endmodule
bind loop_det_output loop_det_output_monitor #(.NCH(NCH)) mon (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .presence_i(presence_i), .loop_open_i(loop_open_i),
    .timing_allow_i(timing_allow_i), .timing_block_i(timing_block_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .detect_o(detect_o), .relay_coil_o(relay_coil_o), .ssr_on_o(ssr_on_o),
    .indicator_o(indicator_o));

// ==== bench/sig_ctrl_model.sv ====
// Signal controller model reading the detector outputs as calls
`timescale 1ns/1ps
module sig_ctrl_model #(
    parameter int unsigned NCH = 2
) (
    input  wire logic           clk_i,
    input  wire logic           rst_n_i,
    input  wire logic [NCH-1:0] relay_coil_i,
    input  wire logic [NCH-1:0] ssr_on_i,
    input  wire logic [NCH-1:0] ssr_sel_i,
    output logic      [NCH-1:0] call_o
);
    // Dead coil means closed contacts, so it reads as a call; dead switch reads as none
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            call_o <= '0;
        end else begin
            call_o <= (ssr_sel_i & ssr_on_i) | (~ssr_sel_i & ~relay_coil_i);
        end
    end
endmodule

// ==== bench/loop_det_output_tb_top.sv ====
// Self-checking testbench for the loop detector output block
`timescale 1ns/1ps
module loop_det_output_tb_top;
    localparam int          LIMIT = 20000;         // Run needs about 3000 cycles
    // Short tick so real timer expiry fits in the run: 1 tick = 10 cycles
    localparam int          TICK  = 10;
    localparam logic [31:0] CH1   = 32'h0000_1000; // Channel 1 wired as solid-state
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0]  pres, lopen, allow, blk, det, coil, ssr, ind, call;
    int          n_errors = 0, num_checks = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    loop_det_output #(.NCH(2), .TICK_CYCLES(TICK)) DUT (
        .core_clk_i(clk), .rst_n_i(rst_n), .presence_i(pres), .loop_open_i(lopen),
        .timing_allow_i(allow), .timing_block_i(blk), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .detect_o(det), .relay_coil_o(coil), .ssr_on_o(ssr), .indicator_o(ind));
    sig_ctrl_model #(.NCH(2)) ctrl (
        .clk_i(clk), .rst_n_i(rst_n), .relay_coil_i(coil), .ssr_on_i(ssr), .ssr_sel_i(2'b10), .call_o(call));
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; waits for ready, the bench timeout catches a dead slave
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setp(input logic [1:0] v, input int n);
        @(posedge clk);
        pres <= v;
        repeat (n) @(posedge clk);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_regs();
        apb(1'b0, loop_det_pkg::ADDR_CTRL, 32'h0);
        check("ctrl_reset", rdat, 32'h0);
        check("coil_idle", coil, 2'b11);
        apb(1'b1, loop_det_pkg::ADDR_ID, 32'h5a);
        apb(1'b0, loop_det_pkg::ADDR_ID, 32'h0);
        check("id", rdat, 32'h0000_0001);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped_err", rerr, 1'b1);
        apb(1'b0, loop_det_pkg::ADDR_RETUNE, 32'h0);
        check("retune_err", rerr, 1'b0);
        check("retune_rd", rdat, 32'h0);
    endtask
    task automatic s_normal();
        apb(1'b1, loop_det_pkg::ADDR_CTRL, CH1);
        setp(2'b11, 8);
        check("on", {ind, det, call}, 6'h3f);
        check("on_out", {coil[0], ssr[1]}, 2'b01);
        apb(1'b0, loop_det_pkg::ADDR_STATUS, 32'h0);
        check("status", rdat[15:0], 16'h0303);
        setp(2'b00, 8);
        check("off", {ind, det, call}, 6'h00);
        check("off_out", {coil[0], ssr[1]}, 2'b10);
    endtask
    // Zero time, allow low, block high, allow low in delay, selector unused code 3
    task automatic s_table();
        logic [31:0] cfg [5] = '{32'h002, 32'h0f2, 32'h0f2, 32'h1e1, 32'h0f3};
        logic [4:0]  al = 5'b10101;
        logic [4:0]  bl = 5'b00100;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, loop_det_pkg::ADDR_CTRL, CH1 | cfg[i]);
            allow <= {2{al[i]}};
            blk <= {2{bl[i]}};
            setp(2'b01, 6);
            check("tbl_on", det[0], 1'b1);
            setp(2'b00, 6);
            check("tbl_off", det[0], 1'b0);
        end
    endtask
    // Half-second extension (50 ticks, about 500 cycles): hold, re-entry, expiry
    task automatic s_extend();
        apb(1'b1, loop_det_pkg::ADDR_CTRL, CH1 | 32'h012);
        setp(2'b01, 6);
        setp(2'b00, 300);
        check("ext_hold", det[0], 1'b1);
        setp(2'b01, 6);
        setp(2'b00, 300);
        check("ext_reentry", det[0], 1'b1);
        setp(2'b00, 300);
        check("ext_done", det[0], 1'b0);
        setp(2'b01, 6);
        setp(2'b00, 10);
        apb(1'b1, loop_det_pkg::ADDR_RETUNE, 32'h1);
        repeat (6) @(posedge clk);
        check("retune", {det[0], call[0]}, 2'b00);
        setp(2'b01, 6);
        setp(2'b00, 10);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check("in_reset", {det, coil, call}, 6'h00);
        rst_n <= 1'b1;
        apb(1'b0, loop_det_pkg::ADDR_CTRL, 32'h0);
        check("det_after", det[0], 1'b0);
        check("ctrl_after", rdat, 32'h0);
    endtask
    // One-second delay (100 ticks, about 1000 cycles): early leave clears timer
    task automatic s_delay();
        apb(1'b1, loop_det_pkg::ADDR_CTRL, CH1 | 32'h011);
        setp(2'b01, 500);
        check("dly_wait", {det[0], coil[0]}, 2'b01);
        setp(2'b00, 10);
        setp(2'b01, 600);
        check("dly_clear", det[0], 1'b0);
        setp(2'b01, 500);
        check("dly_on", {det[0], coil[0]}, 2'b10);
        setp(2'b00, 10);
        check("dly_gone", det[0], 1'b0);
    endtask
    // Pulse mode: 12 ticks (about 120 cycles) from entry, none while presence stays
    task automatic s_pulse();
        apb(1'b1, loop_det_pkg::ADDR_CTRL, CH1 | 32'h004);
        setp(2'b01, 60);
        check("pulse_on", det[0], 1'b1);
        setp(2'b01, 100);
        check("pulse_end", det[0], 1'b0);
        setp(2'b00, 10);
        check("pulse_idle", det[0], 1'b0);
    endtask
    task automatic s_loop();
        apb(1'b1, loop_det_pkg::ADDR_CTRL, CH1);
        lopen <= 2'b11;
        repeat (8) @(posedge clk);
        check("open", {det, coil[0], ssr[1], call}, 6'h37);
        lopen <= 2'b00;
        repeat (8) @(posedge clk);
        check("closed", det, 2'b00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {pres, lopen, allow, blk} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_normal();
        s_table();
        s_extend();
        s_delay();
        s_pulse();
        s_loop();
        close_out();
    end
endmodule
